/* File: rtl/reset_status_clock_gating.sv */
// Reset source recording, oscillator gating, clock switch and divider.
// Assumes an APB master on clk and reset only from the analog domain.
`timescale 1ns/10ps
`default_nettype none
module reset_status_clock_gating #(
  parameter int unsigned SLOW_RC_CYC = rcc_pkg::SLOW_RC_SETUP_CYC,
  parameter int unsigned SLOW_XTAL_CYC = rcc_pkg::SLOW_XTAL_SETUP_CYC,
  parameter int unsigned FAST_XTAL_CYC = rcc_pkg::FAST_XTAL_SETUP_CYC,
  parameter int unsigned PLL_CYC = rcc_pkg::PLL_SETUP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rcc_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset sources
  input wire logic pinResetEvt,
  input wire logic lvrResetEvt,
  input wire logic bodResetEvt,
  input wire logic chipResetEvt,
  input wire logic coreSysResetReq,
  input wire logic wdtTimeout,
  input wire logic wwdtTimeout,
  output logic wdtResetReq,
  output logic coreResetReq,
  // Oscillators
  input wire logic [rcc_pkg::NUM_OSC-1:0] oscClkPin,
  output logic [rcc_pkg::NUM_OSC-1:0] oscEnable,
  output logic [rcc_pkg::NUM_OSC-1:0] oscStable,
  output logic [1:0] lowSpeedClk,
  // System clock
  output logic [2:0] srcGate,
  output logic sysClkEn,
  // Configuration outputs
  output logic [31:0] periphResetCtrl0,
  output logic [31:0] periphResetCtrl1,
  output logic [31:0] brownoutCtrl,
  output logic [31:0] debounceCtrl,
  output logic [31:0] busClkGate,
  output logic [31:0] apb1ClkGate,
  output logic [31:0] apb2ClkGate,
  output logic [31:0] trimClkCtrl,
  // Interrupt
  output logic irq
);
  import rcc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] rstFlags;
    logic [31:0] prst0;
    logic [31:0] prst1;
    logic [31:0] brownout;
    logic [31:0] debounce;
    logic [31:0] clkGlobal;
    logic [NUM_OSC-1:0][31:0] osc;
    logic [3:0][31:0] gateRegs;
    logic [NUM_IRQ-1:0] irqSts;
    logic [NUM_IRQ-1:0] irqEn;
    sw_state_t swState;
    logic [1:0] curSrc;
    logic [1:0] pendSrc;
    logic [2:0] gate;
    logic prevLevel;
    logic [7:0] divCnt;
    logic tick;
    logic coreReq;
    logic wdtReq;
    logic [31:0] rdata;
    logic slverr;
  } rcc_state_t;

  rcc_state_t s;
  rcc_state_t next_s;
  logic [NUM_OSC-1:0] stableVec;
  logic [NUM_OSC-1:0] riseVec;
  logic [NUM_OSC-1:0] gatedVec;
  logic [7:0] flagSet;
  logic [7:0] flagClr;
  logic wdtIssue;
  logic wrAcc;
  logic selLevel;
  logic [1:0] reqSrc;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  // Only three codes name a system clock; slow clocks have none
  function automatic logic srcLegal(input logic [1:0] src);
    srcLegal = (src == SRC_FAST_RC) || (src == SRC_FAST_XTAL) || (src == SRC_PLL);
  endfunction

  function automatic logic srcStable(input logic [1:0] src, input logic [NUM_OSC-1:0] st);
    case (src)
      SRC_FAST_RC: srcStable = st[OSC_FAST_RC];
      SRC_FAST_XTAL: srcStable = st[OSC_FAST_XTAL];
      SRC_PLL: srcStable = st[OSC_PLL];
      default: srcStable = 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] srcOneHot(input logic [1:0] src);
    case (src)
      SRC_FAST_RC: srcOneHot = 3'h1;
      SRC_FAST_XTAL: srcOneHot = 3'h2;
      SRC_PLL: srcOneHot = 3'h4;
      default: srcOneHot = 3'h0;
    endcase
  endfunction

  function automatic logic isMapped(input logic [APB_AW-1:0] a);
    isMapped = (a[1:0] == 2'h0) && (a <= OFF_IRQ_CLR);
  endfunction

  // ****************************************************************
  // Oscillator timers and gates
  // ****************************************************************
  function automatic int unsigned setupOf(input int i);
    case (i)
      OSC_SLOW_RC: setupOf = SLOW_RC_CYC;
      OSC_FAST_RC: setupOf = FAST_RC_SETUP_CYC;
      OSC_SLOW_XTAL: setupOf = SLOW_XTAL_CYC;
      OSC_FAST_XTAL: setupOf = FAST_XTAL_CYC;
      default: setupOf = PLL_CYC;
    endcase
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OSC; gi++) begin : g_osc
      osc_stable_gate #(
        .SETUP_CYC(setupOf(gi)),
        .CNT_W(32)
      ) u_gate (
        .clk(clk),
        .sys_rst(sys_rst),
        .oscEnable(s.osc[gi][BIT_OSC_EN]),
        .delaySel(s.osc[gi][BIT_STB_SEL+:2]),
        .oscClkPin(oscClkPin[gi]),
        .stableFlag(stableVec[gi]),
        .stableRise(riseVec[gi]),
        .gatedClk(gatedVec[gi])
      );
      assign oscEnable[gi] = s.osc[gi][BIT_OSC_EN];
    end
  endgenerate

  // Slow clocks go out only as low-speed clocks
  assign lowSpeedClk = {gatedVec[OSC_SLOW_XTAL], gatedVec[OSC_SLOW_RC]}; // [RQ8]

  // ****************************************************************
  // Reset flag causes
  // ****************************************************************
  // Time-out resets only when software allows it; window one always does
  assign wdtIssue = (wdtTimeout & s.clkGlobal[BIT_WDOG_RST_EN]) | wwdtTimeout; // [RQ2] [RQ16]
  assign wrAcc = psel & penable & pwrite & isMapped(paddr);

  always_comb begin
    flagSet = 8'h00;
    flagSet[BIT_CHIP_RF] = chipResetEvt;
    flagSet[BIT_PIN_RF] = pinResetEvt;
    flagSet[BIT_WDOG_RF] = wdtIssue; // [RQ1]
    flagSet[BIT_LVR_RF] = lvrResetEvt;
    flagSet[BIT_BOD_RF] = bodResetEvt;
    flagSet[BIT_SYS_RF] = coreSysResetReq; // [RQ13]
    flagSet[BIT_CORE_RF] = wrAcc && (paddr == OFF_PRST0) && pwdata[BIT_CORE_REQ]; // [RQ11]
    flagClr = (wrAcc && (paddr == OFF_RST_STS)) ? pwdata[7:0] : 8'h00; // [RQ14]
  end

  // Selected, undivided source level feeding the divider
  assign selLevel = |(s.gate & {gatedVec[OSC_PLL], gatedVec[OSC_FAST_XTAL],
                                gatedVec[OSC_FAST_RC]}); // [RQ9]
  assign reqSrc = s.clkGlobal[BIT_SRC_SEL+:2];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.coreReq = 1'b0;
    next_s.tick = 1'b0;
    next_s.wdtReq = wdtIssue;
    // Setup phase captures read data, so the access needs no wait
    if (psel && !penable) begin
      next_s.slverr = !isMapped(paddr);
      case (paddr)
        OFF_RST_STS: next_s.rdata = {24'h0, s.rstFlags};
        OFF_PRST0: next_s.rdata = s.prst0;
        OFF_PRST1: next_s.rdata = s.prst1;
        OFF_BROWNOUT: next_s.rdata = s.brownout;
        OFF_DEBOUNCE: next_s.rdata = s.debounce;
        OFF_CLK_GLOBAL: next_s.rdata = s.clkGlobal;
        OFF_SLOW_RC: next_s.rdata = s.osc[OSC_SLOW_RC];
        OFF_FAST_RC: next_s.rdata = s.osc[OSC_FAST_RC];
        OFF_SLOW_XTAL: next_s.rdata = s.osc[OSC_SLOW_XTAL];
        OFF_FAST_XTAL: next_s.rdata = s.osc[OSC_FAST_XTAL];
        OFF_PLL: next_s.rdata = s.osc[OSC_PLL];
        OFF_BUS_GATE: next_s.rdata = s.gateRegs[0];
        OFF_APB1_GATE: next_s.rdata = s.gateRegs[1];
        OFF_APB2_GATE: next_s.rdata = s.gateRegs[2];
        OFF_TRIM_GATE: next_s.rdata = s.gateRegs[3];
        OFF_CLK_STS: next_s.rdata = {19'h0, s.swState != SW_RUN, 2'h0,
                                     s.curSrc, 3'h0, stableVec};
        OFF_IRQ_STS: next_s.rdata = {26'h0, s.irqSts};
        OFF_IRQ_EN: next_s.rdata = {26'h0, s.irqEn};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    // Register writes at the access edge
    if (wrAcc) begin
      case (paddr)
        OFF_PRST0: begin
          next_s.prst0 = pwdata;
          next_s.prst0[BIT_CORE_REQ] = 1'b0; // Self-clearing request
          next_s.coreReq = pwdata[BIT_CORE_REQ];
        end
        OFF_PRST1: next_s.prst1 = pwdata;
        OFF_BROWNOUT: next_s.brownout = pwdata;
        OFF_DEBOUNCE: next_s.debounce = pwdata;
        OFF_CLK_GLOBAL: next_s.clkGlobal = pwdata;
        OFF_SLOW_RC: next_s.osc[OSC_SLOW_RC] = pwdata;
        OFF_FAST_RC: next_s.osc[OSC_FAST_RC] = pwdata;
        OFF_SLOW_XTAL: next_s.osc[OSC_SLOW_XTAL] = pwdata;
        OFF_FAST_XTAL: next_s.osc[OSC_FAST_XTAL] = pwdata;
        OFF_PLL: next_s.osc[OSC_PLL] = pwdata;
        OFF_BUS_GATE: next_s.gateRegs[0] = pwdata;
        OFF_APB1_GATE: next_s.gateRegs[1] = pwdata;
        OFF_APB2_GATE: next_s.gateRegs[2] = pwdata;
        OFF_TRIM_GATE: next_s.gateRegs[3] = pwdata;
        OFF_IRQ_EN: next_s.irqEn = pwdata[NUM_IRQ-1:0];
        default: next_s.prst1 = s.prst1;
      endcase
    end
    // Sticky flags: a set in the clearing cycle survives
    next_s.rstFlags = (s.rstFlags & ~flagClr) | flagSet; // [RQ14]
    // Glitch-free switch: drop the old gate a cycle, then open the new
    case (s.swState)
      SW_RUN: begin
        if (srcLegal(reqSrc) && reqSrc != s.curSrc && srcStable(reqSrc, stableVec)) begin
          next_s.pendSrc = reqSrc; // [RQ3] [RQ17]
          next_s.swState = SW_OFF;
        end
      end
      SW_OFF: begin
        next_s.curSrc = s.pendSrc;
        next_s.swState = SW_ON;
      end
      SW_ON: next_s.swState = SW_RUN;
      default: next_s.swState = SW_RUN;
    endcase
    next_s.gate = (next_s.swState == SW_OFF) ? 3'h0 : srcOneHot(next_s.curSrc);
    // Divider counts edges of the selected source
    next_s.prevLevel = selLevel;
    if (selLevel && !s.prevLevel) begin
      if (s.divCnt >= s.clkGlobal[BIT_SYS_DIV+:8]) begin
        next_s.divCnt = 8'h00;
        next_s.tick = 1'b1; // [RQ10]
      end else begin
        next_s.divCnt = s.divCnt + 8'h01;
      end
    end
    // Interrupt status: write-one clear, set wins
    next_s.irqSts = s.irqSts;
    if (wrAcc && paddr == OFF_IRQ_CLR) begin
      next_s.irqSts = s.irqSts & ~pwdata[NUM_IRQ-1:0];
    end
    next_s.irqSts[NUM_OSC-1:0] = next_s.irqSts[NUM_OSC-1:0] | riseVec;
    if (s.swState == SW_ON) begin
      next_s.irqSts[IRQ_SW_DONE] = 1'b1;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Only the analog reset clears this block, so flags outlive system resets
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
      s.rstFlags <= RST_STS_RESET; // [RQ12] [RQ15]
      s.brownout <= BROWNOUT_RESET;
      s.debounce <= DEBOUNCE_RESET;
      s.osc[OSC_SLOW_RC] <= SLOW_RC_RESET;
      s.osc[OSC_FAST_RC] <= FAST_RC_RESET;
      s.osc[OSC_SLOW_XTAL] <= SLOW_XTAL_RESET;
      s.osc[OSC_FAST_XTAL] <= FAST_XTAL_RESET;
      s.osc[OSC_PLL] <= PLL_RESET;
      s.gateRegs[0] <= BUS_GATE_RESET;
      s.gateRegs[3] <= TRIM_GATE_RESET;
      s.swState <= SW_RUN;
      s.curSrc <= SRC_FAST_RC; // [RQ4]
      s.gate <= 3'h1;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = s.rdata;
  assign pready = 1'b1;
  assign pslverr = s.slverr & psel & penable;
  assign wdtResetReq = s.wdtReq;
  assign coreResetReq = s.coreReq;
  assign oscStable = stableVec;
  assign srcGate = s.gate;
  assign sysClkEn = s.tick;
  assign periphResetCtrl0 = s.prst0;
  assign periphResetCtrl1 = s.prst1;
  assign brownoutCtrl = s.brownout;
  assign debounceCtrl = s.debounce;
  assign busClkGate = s.gateRegs[0];
  assign apb1ClkGate = s.gateRegs[1];
  assign apb2ClkGate = s.gateRegs[2];
  assign trimClkCtrl = s.gateRegs[3];
  assign irq = |(s.irqSts & s.irqEn);

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_wdog_flag: assert property (@(posedge clk) disable iff (sys_rst) // [RQ1] [RQ16]
    wwdtTimeout |=> s.rstFlags[BIT_WDOG_RF] && wdtResetReq)
    else $error("window watchdog reset not recorded");
  a_wdog_masked: assert property (@(posedge clk) disable iff (sys_rst) // [RQ2]
    wdtTimeout && !wwdtTimeout && !s.clkGlobal[BIT_WDOG_RST_EN] |=> !wdtResetReq)
    else $error("disabled watchdog time-out reset the system");
  a_gate_legal: assert property (@(posedge clk) disable iff (sys_rst) // [RQ3] [RQ8]
    $onehot0(srcGate) && s.curSrc != 2'h3)
    else $error("illegal system clock gate");
  a_boot_source: assert property (@(posedge clk) // [RQ4] [RQ15]
    $past(sys_rst) && !sys_rst |-> s.curSrc == SRC_FAST_RC && s.rstFlags == 8'h40)
    else $error("wrong state after reset");
  a_core_flag: assert property (@(posedge clk) disable iff (sys_rst) // [RQ11]
    coreResetReq |-> s.rstFlags[BIT_CORE_RF] && !s.prst0[BIT_CORE_REQ])
    else $error("core reset not recorded");
  a_sys_flag: assert property (@(posedge clk) disable iff (sys_rst) // [RQ13]
    coreSysResetReq |=> s.rstFlags[BIT_SYS_RF])
    else $error("system reset request not recorded");
  a_zero_keeps: assert property (@(posedge clk) disable iff (sys_rst) // [RQ14]
    wrAcc && paddr == OFF_RST_STS && !pwdata[BIT_POR_RF] && s.rstFlags[BIT_POR_RF]
    |=> s.rstFlags[BIT_POR_RF])
    else $error("writing zero cleared a reset flag");
  a_switch_gap: assert property (@(posedge clk) disable iff (sys_rst) // [RQ17]
    s.swState == SW_RUN ##1 s.swState == SW_OFF |->
    srcGate == 3'h0 ##1 srcGate == srcOneHot(s.curSrc) && srcStable(s.curSrc, stableVec))
    else $error("clock switch not glitch-free");
  a_div_spacing: assert property (@(posedge clk) disable iff (sys_rst) // [RQ10]
    sysClkEn && s.clkGlobal[BIT_SYS_DIV+:8] != 8'h00 |=> !sysClkEn)
    else $error("divided clock enable too close");
endmodule
`default_nettype wire

/* File: rtl/rcc_pkg.sv */
// Constants, register map and types of the reset status and clock block.
// Assumes a 100 MHz clk and a 32-bit APB with byte addresses in 8 bits.
// Operation
// (RQ1) Watchdog reset flag lives at status bit 2
// (RQ2) Software chooses whether watchdog time-out resets
// (RQ3) System clock only from fast RC, crystal, PLL
// (RQ4) Fast RC is the system clock after power-on
// (RQ5) Clock passes only after its start-up time
// (RQ6) Two-bit setting stretches each stable delay
// (RQ7) Each clock gated by its own stable flag
// (RQ8) Slow clocks never selectable as system clock
// (RQ9) PLL reaches the selector undivided
// (RQ10) Programmable divider follows the source selector
// (RQ11) Core-only reset request sets status bit 7
// (RQ12) Power-on reset sets status bit 6
// (RQ13) Processor system reset request sets bit 5
// (RQ14) Flags clear on writing one, zero keeps
// (RQ15) Status reads 0x40 after reset
// (RQ16) Either watchdog's reset sets the watchdog flag
// (RQ17) Glitch-free switch, only to a stable source
package rcc_pkg;
  // ****************************************************************
  // Bus and register offsets
  // ****************************************************************
  localparam int APB_AW = 8;
  localparam logic [7:0] OFF_RST_STS = 8'h00;
  localparam logic [7:0] OFF_PRST0 = 8'h04;
  localparam logic [7:0] OFF_PRST1 = 8'h08;
  localparam logic [7:0] OFF_BROWNOUT = 8'h0C;
  localparam logic [7:0] OFF_DEBOUNCE = 8'h10;
  localparam logic [7:0] OFF_CLK_GLOBAL = 8'h14;
  localparam logic [7:0] OFF_SLOW_RC = 8'h18;
  localparam logic [7:0] OFF_FAST_RC = 8'h1C;
  localparam logic [7:0] OFF_SLOW_XTAL = 8'h20;
  localparam logic [7:0] OFF_FAST_XTAL = 8'h24;
  localparam logic [7:0] OFF_PLL = 8'h28;
  localparam logic [7:0] OFF_BUS_GATE = 8'h2C;
  localparam logic [7:0] OFF_APB1_GATE = 8'h30;
  localparam logic [7:0] OFF_APB2_GATE = 8'h34;
  localparam logic [7:0] OFF_TRIM_GATE = 8'h38;
  localparam logic [7:0] OFF_CLK_STS = 8'h3C;
  localparam logic [7:0] OFF_IRQ_STS = 8'h40;
  localparam logic [7:0] OFF_IRQ_EN = 8'h44;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h48;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_STS_RESET = 8'h40;
  localparam logic [31:0] BROWNOUT_RESET = 32'h000C_0040;
  localparam logic [31:0] DEBOUNCE_RESET = 32'h0000_0101;
  localparam logic [31:0] SLOW_RC_RESET = 32'h0104_8081;
  localparam logic [31:0] FAST_RC_RESET = 32'h0103_5021;
  localparam logic [31:0] SLOW_XTAL_RESET = 32'h0003_1020;
  localparam logic [31:0] FAST_XTAL_RESET = 32'h0000_0020;
  localparam logic [31:0] PLL_RESET = 32'h0000_1480;
  localparam logic [31:0] BUS_GATE_RESET = 32'h0010_C264;
  localparam logic [31:0] TRIM_GATE_RESET = 32'h00F4_0000;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_CHIP_RF = 0;
  localparam int BIT_PIN_RF = 1;
  localparam int BIT_WDOG_RF = 2;
  localparam int BIT_LVR_RF = 3;
  localparam int BIT_BOD_RF = 4;
  localparam int BIT_SYS_RF = 5;
  localparam int BIT_POR_RF = 6;
  localparam int BIT_CORE_RF = 7;
  localparam int BIT_CORE_REQ = 1;
  localparam int BIT_OSC_EN = 0;
  localparam int BIT_STB_SEL = 4;
  localparam int BIT_SRC_SEL = 0;
  localparam int BIT_SYS_DIV = 4;
  localparam int BIT_WDOG_RST_EN = 16;
  localparam int BIT_SW_BUSY = 12;
  localparam int BIT_CUR_SRC = 8;
  // Oscillator index order, also the order of stable flags
  localparam int OSC_SLOW_RC = 0;
  localparam int OSC_FAST_RC = 1;
  localparam int OSC_SLOW_XTAL = 2;
  localparam int OSC_FAST_XTAL = 3;
  localparam int OSC_PLL = 4;
  localparam int NUM_OSC = 5;
  localparam int IRQ_SW_DONE = 5;
  localparam int NUM_IRQ = 6;
  // System clock source codes
  localparam logic [1:0] SRC_FAST_RC = 2'h0;
  localparam logic [1:0] SRC_FAST_XTAL = 2'h1;
  localparam logic [1:0] SRC_PLL = 2'h2;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int SLOW_XTAL_SETUP_MS = 200;
  localparam int FAST_RC_SETUP_US = 5;
  localparam int FAST_XTAL_SETUP_US = 200;
  localparam int SLOW_RC_SETUP_US = 100;
  localparam int PLL_SETUP_US = 20;
  localparam int SLOW_XTAL_SETUP_CYC = SLOW_XTAL_SETUP_MS * 1000 * CLK_MHZ;
  localparam int FAST_RC_SETUP_CYC = FAST_RC_SETUP_US * CLK_MHZ;
  localparam int FAST_XTAL_SETUP_CYC = FAST_XTAL_SETUP_US * CLK_MHZ;
  localparam int SLOW_RC_SETUP_CYC = SLOW_RC_SETUP_US * CLK_MHZ;
  localparam int PLL_SETUP_CYC = PLL_SETUP_US * CLK_MHZ;
  localparam int STB_STEP_CYC = 16;
  // Clock switch sequence
  typedef enum logic [2:0] {
    SW_RUN = 3'b001,
    SW_OFF = 3'b010,
    SW_ON = 3'b100
  } sw_state_t;
endpackage

/* File: rtl/osc_stable_gate.sv */
// One oscillator's start-up timer, stable flag and digital-side gate.
// Assumes the oscillator clock pin is asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module osc_stable_gate #(
  parameter int unsigned SETUP_CYC = 500,
  parameter int CNT_W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic oscEnable,
  input wire logic [1:0] delaySel,
  // Analog side
  input wire logic oscClkPin,
  // Digital side
  output logic stableFlag,
  output logic stableRise,
  output logic gatedClk
);
  import rcc_pkg::*;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [CNT_W-1:0] cnt;
    logic stable;
    logic rise;
    logic gated;
  } osc_state_t;

  osc_state_t s;
  osc_state_t next_s;
  logic [CNT_W-1:0] target;

  // Setup time plus the programmable stable stretch
  assign target = CNT_W'(SETUP_CYC) + CNT_W'(delaySel) * CNT_W'(STB_STEP_CYC); // [RQ6]

  // Start-up count, restarted whenever the enable drops
  always_comb begin
    next_s = s;
    next_s.sync1 = oscClkPin;
    next_s.sync2 = s.sync1;
    next_s.rise = 1'b0;
    if (!oscEnable) begin
      next_s.cnt = '0;
      next_s.stable = 1'b0;
    end else if (!s.stable) begin
      if (s.cnt >= target) begin
        next_s.stable = 1'b1; // [RQ5]
        next_s.rise = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 1'b1;
      end
    end
    // Gate opens only behind the stable flag
    next_s.gated = s.sync2 & s.stable; // [RQ7]
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign stableFlag = s.stable;
  assign stableRise = s.rise;
  assign gatedClk = s.gated;

  a_setup_wait: assert property (@(posedge clk) disable iff (sys_rst) // [RQ5]
    $rose(stableFlag) |-> $past(s.cnt) >= CNT_W'(SETUP_CYC))
    else $error("stable flag rose before the start-up time");
  a_gate_closed: assert property (@(posedge clk) disable iff (sys_rst) // [RQ7]
    !$past(stableFlag) |-> !gatedClk)
    else $error("clock passed while not stable");
endmodule
`default_nettype wire

/* File: verif/osc_model.sv */
// Behavioural oscillators and PLL on the far side of the clock gates.
// Assumes the block enables each source; a disabled source stands still low.
`timescale 1ns/10ps
`default_nettype none
module osc_model (
  // Enables from the block
  input wire logic [rcc_pkg::NUM_OSC-1:0] oscEnable,
  // Raw clock pins
  output logic [rcc_pkg::NUM_OSC-1:0] oscClkPin
);
  import rcc_pkg::*;
  // ****
  // Free-running sources; edges drift across clk, the gates resynchronise them
  // ****
  initial begin
    oscClkPin = 5'h00;
    forever begin
      #7;
      oscClkPin = ~oscClkPin & oscEnable;
    end
  end
endmodule
`default_nettype wire

/* File: verif/reset_status_clock_gating_tb.sv */
// Self-checking bench: APB master, reset event pulses, oscillator model.
// Assumes the package constants and short start-up parameters set here.
`timescale 1ns/10ps
`default_nettype none
module reset_status_clock_gating_tb;
  import rcc_pkg::*;
  localparam int FXC = 40;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, sysEn;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, prc0, prc1, lfsr;
  logic [6:0] evt;
  logic [4:0] oscClk, oscEn, oscStable;
  logic [2:0] srcGate;
  logic [31:0] expQ[$];
  int failCount = 0;
  int nTests = 0;
  int bitOf[5] = '{1, 3, 4, 0, 5};
  int i, k;
  reset_status_clock_gating #(.SLOW_RC_CYC(20), .SLOW_XTAL_CYC(50), .FAST_XTAL_CYC(FXC),
    .PLL_CYC(30)) dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinResetEvt(evt[0]), .lvrResetEvt(evt[1]), .bodResetEvt(evt[2]),
    .chipResetEvt(evt[3]), .coreSysResetReq(evt[4]), .wdtTimeout(evt[5]),
    .wwdtTimeout(evt[6]), .wdtResetReq(), .coreResetReq(), .oscClkPin(oscClk),
    .oscEnable(oscEn), .oscStable(oscStable), .lowSpeedClk(), .srcGate(srcGate),
    .sysClkEn(sysEn), .periphResetCtrl0(prc0), .periphResetCtrl1(prc1), .brownoutCtrl(),
    .debounceCtrl(), .busClkGate(), .apb1ClkGate(), .apb2ClkGate(), .trimClkCtrl(),
    .irq(irq));
  osc_model osc (.oscEnable(oscEn), .oscClkPin(oscClk));
  // ****
  // Shared tasks
  // ****
  task automatic stopTest();
    $display("checks %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    nTests++;
    if (s !== e) begin
      failCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // A wait that runs out ends the run rather than hanging
  task automatic lim(input int n);
    if (n >= 9000) begin
      failCount++;
      stopTest();
    end
  endtask
  // Next word of the stimulus sequence
  function automatic logic [31:0] lfsrNext(input logic [31:0] v);
    lfsrNext = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 9000);
    lim(n);
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following setup never rewrites psel in this step
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic pulse(input int b);
    evt[b] <= 1'b1;
    @(posedge clk);
    evt[b] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // Read results are compared at the access edge, oldest note first
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && expQ.size() > 0) chk(prdata, expQ.pop_front());
    if (psel && penable && pready) chk(pslverr, paddr > OFF_IRQ_CLR || paddr[1:0] != 2'h0);
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #1000000;
    failCount++;
    stopTest();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    evt = 7'h00;
    lfsr = 32'h33484016;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(srcGate, 32'h1);
    chk(oscEn, 32'h3);
    rd(OFF_RST_STS, 32'h40);
    rd(OFF_BROWNOUT, BROWNOUT_RESET);
    rd(OFF_PLL, PLL_RESET);
    rd(8'h80, 32'h0);
    wr(OFF_RST_STS, 32'h0);
    rd(OFF_RST_STS, 32'h40);
    for (i = 0; i < 5; i++) begin
      wr(OFF_RST_STS, 32'hFF);
      pulse(i);
      rd(OFF_RST_STS, 32'h1 << bitOf[i]);
    end
    wr(OFF_RST_STS, 32'hFF);
    pulse(6);
    rd(OFF_RST_STS, 32'h4);
    wr(OFF_RST_STS, 32'h4);
    pulse(5);
    rd(OFF_RST_STS, 32'h0);
    wr(OFF_CLK_GLOBAL, 32'h0001_0000);
    pulse(5);
    rd(OFF_RST_STS, 32'h4);
    wr(OFF_RST_STS, 32'hFF);
    wr(OFF_PRST0, 32'h2);
    repeat (3) @(posedge clk);
    chk(prc0, 32'h0);
    rd(OFF_RST_STS, 32'h80);
    // Random words through a plain read-write register
    for (i = 0; i < 4; i++) begin
      lfsr = lfsrNext(lfsr);
      wr(OFF_PRST1, lfsr);
      rd(OFF_PRST1, lfsr);
      chk(prc1, lfsr);
    end
    wr(OFF_IRQ_EN, 32'h20);
    wr(OFF_CLK_GLOBAL, 32'h3);
    repeat (4) @(posedge clk);
    chk(srcGate, 32'h1);
    wr(OFF_CLK_GLOBAL, 32'h1);
    repeat (4) @(posedge clk);
    chk(srcGate, 32'h1);
    wr(OFF_FAST_XTAL, FAST_XTAL_RESET | 32'h1);
    k = 0;
    while (oscStable[OSC_FAST_XTAL] !== 1'b1 && k < 9000) begin
      @(posedge clk);
      k++;
    end
    lim(k);
    chk(k >= FXC + 32, 32'h1);
    k = 0;
    while (srcGate !== 3'h2 && k < 9000) begin
      @(posedge clk);
      k++;
    end
    lim(k);
    repeat (3) @(posedge clk);
    chk(irq, 32'h1);
    wr(OFF_IRQ_CLR, 32'h20);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0);
    // Divide by four: each pulse needs four source rising edges, two cycles apiece
    wr(OFF_CLK_GLOBAL, 32'h31);
    for (i = 0; i < 2; i++) begin
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (sysEn !== 1'b1 && k < 9000);
      lim(k);
    end
    chk(k >= 8, 32'h1);
    stopTest();
  end
endmodule
`default_nettype wire
